// ===== dcw_channel.sv
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Function
// - rearbitrate codes 6..9 give 64..512 transfers; A..F give 1024.
// - rearbitrate codes 0..5 give 1,2,4,8,16,32 transfers.
// - ten-bit count field bits 13:4 holds items minus one.
// - count is in items of the configured width, not bytes.
// - count field written back with outstanding items before arbitration.
// - burst-only and burst bit both clear: remainder below burst size moves as singles.
// - burst-only set: final remainder moves only as a burst.
// - on last peripheral scatter-gather transfer, bit sets burst-only setting.
// - control word has no reset contents; nothing assumed before loading (here reset loads DCW_WORD_RESET, all zero).
// - mode codes 0 stop, 1 basic, 2 auto, 3 ping-pong, 4-6 scatter-gather.
module dcw_channel (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_req,
  output logic o_xfer,
  output logic o_xfer_burst,
  input wire logic i_xfer_ack,
  output logic o_arb,
  output logic o_done
);
  import dcw_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // burst size from rearbitrate code
  function automatic logic [10:0] rearb_items(input logic [3:0] code);
    if (code >= DCW_REARB_MAX_CODE) begin
      rearb_items = 11'h400;
    end else begin
      rearb_items = 11'h001 << code;
    end
  endfunction : rearb_items

  // byte size of one item
  function automatic logic [2:0] item_bytes(input logic [1:0] w);
    item_bytes = (w == 2'h3) ? 3'h0 : (3'h1 << w);
  endfunction : item_bytes

  // items retired by one granted move; the bus acknowledges the whole burst at once
  function automatic logic [10:0] moved_items(input logic [10:0] n);
    moved_items = n;
  endfunction : moved_items

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // engine state and register copies
  dcw_state_t state_q, state_d;
  logic [31:0] word_q, word_d;
  logic [10:0] left_q, left_d;
  logic [10:0] burst_q, burst_d;
  logic en_q, en_d;
  logic loaded_q, loaded_d;
  logic burst_only_q, burst_only_d;
  logic done_q, done_d;
  logic [31:0] rdata_q, rdata_d;
  logic req_s1_q, req_s2_q;
  logic [10:0] total;
  logic [10:0] arb;
  logic [2:0] mode;
  logic last_burst;

  // fields of the loaded control word
  assign mode = word_q[DCW_MODE_LSB +: DCW_MODE_W];
  assign arb = rearb_items(word_q[DCW_REARB_LSB +: DCW_REARB_W]);
  assign total = {1'b0, word_q[DCW_COUNT_LSB +: DCW_COUNT_W]} + 11'h001;
  assign last_burst = word_q[DCW_BURST_BIT];

  // ---------------------------------------------------------------
  // request path
  // ---------------------------------------------------------------
  // request synchroniser; only the second stage feeds the engine
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= i_req;
      req_s2_q <= req_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // register port and transfer engine
  // ---------------------------------------------------------------
  // next-state logic
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    left_d = left_q;
    burst_d = burst_q;
    en_d = en_q;
    loaded_d = loaded_q;
    burst_only_d = burst_only_q;
    done_d = 1'b0;
    rdata_d = 32'h0000_0000;
    // register writes; the engine below may overwrite fields
    if (i_wr && i_addr == DCW_ADDR_WORD) begin
      word_d = i_wdata;
      loaded_d = 1'b1;
    end else if (i_wr && i_addr == DCW_ADDR_CTRL) begin
      en_d = i_wdata[0];
      burst_only_d = i_wdata[1];
    end
    // register reads: one cycle of data, zero otherwise
    if (i_rd) begin
      if (i_addr == DCW_ADDR_WORD) begin
        rdata_d = word_q;
      end else if (i_addr == DCW_ADDR_CTRL) begin
        rdata_d = {30'h0, burst_only_q, en_q};
      end else if (i_addr == DCW_ADDR_STATUS) begin
        rdata_d = {26'h0, item_bytes(word_q[DCW_SRC_WIDTH_LSB +: 2]), state_q};
      end else if (i_addr == DCW_ADDR_LEFT) begin
        rdata_d = {21'h0, left_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
    // transfer engine
    case (state_q)
      DCW_IDLE: begin
        // stop mode or unloaded word never starts a cycle
        if (en_q && loaded_q && mode != DCW_MODE_STOP && mode <= DCW_MODE_PER_SG) begin
          left_d = total;
          state_d = DCW_WAIT_REQ;
        end
      end
      DCW_WAIT_REQ: begin
        if (!en_q) begin
          state_d = DCW_IDLE;
        end else if (req_s2_q) begin
          // burst size chosen once per arbitration
          if (left_q < arb && !last_burst && !burst_only_q) begin
            burst_d = 11'h001;
          end else begin
            burst_d = (left_q < arb) ? left_q : arb;
          end
          if (mode == DCW_MODE_PER_SG && left_q <= arb && last_burst) begin
            burst_only_d = 1'b1;
          end
          state_d = DCW_MOVE;
        end
      end
      DCW_MOVE: begin
        if (i_xfer_ack) begin
          // bus finished the whole move
          left_d = left_q - moved_items(burst_q);
          state_d = DCW_WRITEBACK;
        end
      end
      DCW_WRITEBACK: begin
        // outstanding items minus one back into the count field
        word_d[DCW_COUNT_LSB +: DCW_COUNT_W] = (left_q == 11'h000) ? 10'h000
                                               : 10'(left_q - 11'h001);
        // nothing left ends the cycle and stops the word
        if (left_q == 11'h000) begin
          word_d[DCW_MODE_LSB +: DCW_MODE_W] = DCW_MODE_STOP;
          state_d = DCW_DONE;
        end else if (mode == DCW_MODE_BASIC) begin
          state_d = DCW_WAIT_REQ;
        end else begin
          burst_d = (left_q < arb) ? (last_burst || burst_only_q ? left_q : 11'h001) : arb;
          state_d = (mode == DCW_MODE_AUTO) ? DCW_MOVE : DCW_WAIT_REQ;
        end
      end
      DCW_DONE: begin
        // completion pulse; the channel disables itself
        done_d = 1'b1;
        en_d = 1'b0;
        state_d = DCW_IDLE;
      end
      default: state_d = DCW_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  // registers; reset leaves the word marked unloaded
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= DCW_IDLE;
      word_q <= DCW_WORD_RESET;
      left_q <= 11'h000;
      burst_q <= 11'h001;
      en_q <= 1'b0;
      loaded_q <= 1'b0;
      burst_only_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      left_q <= left_d;
      burst_q <= burst_d;
      en_q <= en_d;
      loaded_q <= loaded_d;
      burst_only_q <= burst_only_d;
      done_q <= done_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // move request and burst flag follow the state directly
  assign o_rdata = rdata_q;
  assign o_xfer = (state_q == DCW_MOVE);
  assign o_xfer_burst = (state_q == DCW_MOVE) && (burst_q != 11'h001);
  assign o_arb = (state_q == DCW_WRITEBACK) && (left_q != 11'h000);
  assign o_done = done_q;
endmodule : dcw_channel

// ===== dcw_pkg.sv
package dcw_pkg;
  // ---------------------------------------------------------------
  // control word layout
  // ---------------------------------------------------------------
  localparam int DCW_DST_WIDTH_LSB = 28;
  localparam int DCW_SRC_WIDTH_LSB = 24;
  localparam int DCW_REARB_LSB = 14;
  localparam int DCW_COUNT_LSB = 4;
  localparam int DCW_BURST_BIT = 3;
  localparam int DCW_MODE_LSB = 0;
  localparam int DCW_COUNT_W = 10;
  localparam int DCW_REARB_W = 4;
  localparam int DCW_MODE_W = 3;
  localparam logic [3:0] DCW_REARB_MAX_CODE = 4'hA;

  // ---------------------------------------------------------------
  // register map of the plain register port
  // ---------------------------------------------------------------
  localparam logic [3:0] DCW_ADDR_WORD = 4'h0;
  localparam logic [3:0] DCW_ADDR_CTRL = 4'h4;
  localparam logic [3:0] DCW_ADDR_STATUS = 4'h8;
  localparam logic [3:0] DCW_ADDR_LEFT = 4'hC;
  localparam logic [31:0] DCW_WORD_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // cycle modes and engine states
  // ---------------------------------------------------------------
  localparam logic [2:0] DCW_MODE_STOP = 3'h0;
  localparam logic [2:0] DCW_MODE_BASIC = 3'h1;
  localparam logic [2:0] DCW_MODE_AUTO = 3'h2;
  localparam logic [2:0] DCW_MODE_PINGPONG = 3'h3;
  localparam logic [2:0] DCW_MODE_MEM_SG_PRI = 3'h4;
  localparam logic [2:0] DCW_MODE_MEM_SG_ALT = 3'h5;
  localparam logic [2:0] DCW_MODE_PER_SG = 3'h6;

  typedef enum logic [2:0] {DCW_IDLE, DCW_WAIT_REQ, DCW_MOVE, DCW_WRITEBACK, DCW_DONE} dcw_state_t;
endpackage : dcw_pkg

// ===== dcw_chk.sv
`timescale 1ns/1ps
module dcw_chk (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_req,
  input wire logic o_xfer,
  input wire logic o_xfer_burst,
  input wire logic i_xfer_ack,
  input wire logic o_arb,
  input wire logic o_done
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // write-back ends in a pulse soon after each ack
  sequence s_end; ##[1:4] (o_arb || o_done); endsequence
  a_done_one_cycle: assert property (o_done |=> !o_done) else $error("done held");
  a_arb_one_cycle: assert property (o_arb |=> !o_arb) else $error("arb held");
  a_xfer_holds: assert property (o_xfer && !i_xfer_ack |=> o_xfer) else $error("xfer drop");
  a_ack_drops: assert property (o_xfer && i_xfer_ack |=> !o_xfer) else $error("xfer stays");
  a_ack_writes_back: assert property (o_xfer && i_xfer_ack |-> s_end) else $error("no wb");
  a_burst_in_move: assert property (o_xfer_burst |-> o_xfer) else $error("lone burst");
  a_arb_not_done: assert property (!(o_arb && o_done)) else $error("arb with done");
  a_rdata_quiet: assert property (!i_rd |=> o_rdata == 32'h0) else $error("rdata");
endmodule : dcw_chk
bind dcw_channel dcw_chk i_dcw_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req),
  .o_xfer(o_xfer), .o_xfer_burst(o_xfer_burst), .i_xfer_ack(i_xfer_ack), .o_arb(o_arb),
  .o_done(o_done));

// ===== dcw_bus_model.sv
`timescale 1ns/1ps
module dcw_bus_model (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_xfer,
  input wire logic i_slow,
  output logic o_ack
);
  logic [2:0] cnt_q, cnt_d;
  logic ack_d;
  // -------------------------------------
  // ack a whole move, fast or after a wait
  // -------------------------------------
  always_comb begin
    cnt_d = (i_xfer && !o_ack) ? cnt_q + 3'h1 : 3'h0;
    ack_d = i_xfer && !o_ack && (cnt_q >= (i_slow ? 3'h4 : 3'h0));
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 3'h0;
      o_ack <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      o_ack <= ack_d;
    end
  end
endmodule : dcw_bus_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import dcw_pkg::*;
  logic i_mclk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, i_req = 0, slow = 0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic o_xfer, o_xfer_burst, i_xfer_ack, o_arb, o_done;
  int n_fail = 0, checks_done = 0, cyc = 0, n_mv, n_bu, n_arb;
  initial forever #12.5 i_mclk = ~i_mclk;
  dcw_channel i_dcw_channel (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req),
    .o_xfer(o_xfer), .o_xfer_burst(o_xfer_burst), .i_xfer_ack(i_xfer_ack), .o_arb(o_arb),
    .o_done(o_done));
  dcw_bus_model i_dcw_bus_model (.i_mclk, .i_rst_b, .i_xfer(o_xfer), .i_slow(slow),
    .o_ack(i_xfer_ack));
  // move, burst and arbitration counters plus timeout
  always @(posedge i_mclk) begin
    cyc++;
    if (o_xfer && i_xfer_ack) begin
      n_mv++;
      n_bu += int'(o_xfer_burst);
    end
    n_arb += int'(o_arb);
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_mclk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_mclk) i_rd <= 1'b0;
    #1 check(o_rdata, e);
  endtask : rd
  function automatic logic [31:0] cw(logic [3:0] rb, logic [9:0] c, logic b, logic [2:0] m);
    return {14'h0, rb, c, b, m};
  endfunction : cw
  task run(input logic [31:0] w, input int mv, input int bu, input int arb);
    n_mv = 0; n_bu = 0; n_arb = 0;
    wr(DCW_ADDR_WORD, w);
    wr(DCW_ADDR_CTRL, 32'h1);
    i_req <= 1'b1;
    for (int k = 0; k < 600 && o_done !== 1'b1; k++) @(posedge i_mclk) #1;
    check(32'(o_done), 32'h1);
    @(posedge i_mclk) i_req <= 1'b0;
    check(n_mv, mv);
    check(n_bu, bu);
    if (arb >= 0) check(n_arb, arb);
    rd(DCW_ADDR_WORD, w & 32'hFFFF_C008);
    rd(DCW_ADDR_LEFT, 32'h0);
  endtask : run
  task t_unloaded;
    rd(DCW_ADDR_STATUS, 32'h0000_0008);
    rd(4'h2, 32'h0);
    wr(DCW_ADDR_CTRL, 32'h1);
    i_req <= 1'b1;
    repeat (10) @(posedge i_mclk);
    check(32'(o_xfer), 32'h0);
    wr(DCW_ADDR_WORD, cw(4'h0, 10'h0, 1'b0, DCW_MODE_STOP) | 32'h0200_0000);
    repeat (10) @(posedge i_mclk);
    check(32'(o_xfer), 32'h0);
    rd(DCW_ADDR_STATUS, 32'h0000_0020);
    wr(DCW_ADDR_WORD, cw(4'h0, 10'h0, 1'b0, 3'h7));
    repeat (10) @(posedge i_mclk);
    check(32'(o_xfer), 32'h0);
    @(posedge i_mclk) i_req <= 1'b0;
    $display("test unloaded done");
  endtask : t_unloaded
  task t_writeback;
    n_arb = 0;
    wr(DCW_ADDR_WORD, cw(4'h1, 10'h4, 1'b0, DCW_MODE_BASIC));
    wr(DCW_ADDR_CTRL, 32'h1);
    i_req <= 1'b1;
    for (int k = 0; k < 50 && o_xfer !== 1'b1; k++) @(posedge i_mclk) #1;
    @(posedge i_mclk) i_req <= 1'b0;
    repeat (10) @(posedge i_mclk);
    check(32'(o_xfer), 32'h0);
    check(n_arb, 1);
    rd(DCW_ADDR_WORD, cw(4'h1, 10'h2, 1'b0, DCW_MODE_BASIC));
    rd(DCW_ADDR_LEFT, 32'h3);
    wr(DCW_ADDR_CTRL, 32'h0);
    $display("test writeback done");
  endtask : t_writeback
  task t_sizes;
    run(cw(4'h0, 10'h1, 1'b0, DCW_MODE_AUTO), 2, 0, 1);
    slow = 1'b1;
    run(cw(4'h2, 10'h5, 1'b0, DCW_MODE_AUTO), 3, 1, 2);
    slow = 1'b0;
    run(cw(4'h2, 10'h5, 1'b1, DCW_MODE_AUTO), 2, 2, 1);
    run(cw(4'h6, 10'h63, 1'b0, DCW_MODE_AUTO), 37, 1, 36);
    run(cw(4'hA, 10'h3FF, 1'b0, DCW_MODE_AUTO), 1, 1, 0);
    run(cw(4'h2, 10'h5, 1'b1, DCW_MODE_PER_SG), 2, 2, 1);
    rd(DCW_ADDR_CTRL, 32'h0000_0002);
    $display("test sizes done");
  endtask : t_sizes
  task t_modes;
    for (int m = 1; m < 7; m++) run(cw(4'h0, 10'h0, 1'b0, 3'(m)), 1, 0, 0);
    $display("test modes done");
  endtask : t_modes
  task finish_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_unloaded();
    t_writeback();
    t_sizes();
    t_modes();
    finish_test();
  end
endmodule : tb
